// ---- rtl/pqtc_consts.svh ----
`ifndef PQTC_CONSTS_SVH
`define PQTC_CONSTS_SVH

// Register addresses, one control pair per port
`define PQTC_P1_CTRL0_ADDR 8'h10
`define PQTC_P1_CTRL1_ADDR 8'h11
`define PQTC_P2_CTRL0_ADDR 8'h20
`define PQTC_P2_CTRL1_ADDR 8'h21
`define PQTC_P3_CTRL0_ADDR 8'h30
`define PQTC_P3_CTRL1_ADDR 8'h31

// Reset values
`define PQTC_CTRL0_RESET 8'h00
`define PQTC_CTRL1_RESET 8'h00
`define PQTC_RDATA_RESET 8'h00

// Control 1 bits held here; the rest read as zero
`define PQTC_CTRL1_MASK 8'he0

// Queue used when a port runs a single output queue
`define PQTC_SINGLE_QUEUE 2'h0
`define PQTC_NO_VID 12'h000

`endif

// ---- rtl/pqtc_pkg.sv ----
package pqtc_pkg;

    // Control 0 layout, msb first: bits 7..0
    typedef struct packed {
        logic storm_protect_en;
        logic diffserv_cls_en;
        logic dot1p_cls_en;
        logic [1:0] port_prio;
        logic tag_insert_en;
        logic tag_remove_en;
        logic multi_queue_en;
    } pqtc_ctrl0_t;

    // Control 1 layout, msb first: bits 7..0
    typedef struct packed {
        logic sniffer_port;
        logic rx_sniff;
        logic tx_sniff;
        logic [4:0] unused;
    } pqtc_ctrl1_t;

    // Management register access
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } pqtc_reg_req_t;

    // Ingress classification request, one per packet
    typedef struct packed {
        logic valid;
        logic dscp_hit;
        logic [1:0] dscp_prio;
        logic dot1p_hit;
        logic [1:0] dot1p_prio;
    } pqtc_cls_req_t;

    typedef struct packed {
        logic valid;
        logic storm_check;
        logic [1:0] prio;
    } pqtc_cls_rsp_t;

    // Egress edit request, one per packet leaving a port
    typedef struct packed {
        logic valid;
        logic rx_tagged;
        logic [1:0] ingress_port;
        logic [1:0] prio;
    } pqtc_egr_req_t;

    typedef struct packed {
        logic valid;
        logic add_tag;
        logic strip_tag;
        logic [11:0] vid;
        logic [1:0] queue;
    } pqtc_egr_rsp_t;

endpackage

// ---- rtl/pqtc_top.sv ----
`timescale 1ns/1ns
`include "pqtc_consts.svh"

module pqtc_top
    import pqtc_pkg::*;
#(
    parameter int NPORT = 3,
    parameter int VID_W = 12
)(
    input wire logic ref_clk_i, // Core clock, 25 MHz
    input wire logic rst_n_i, // Async reset, active low
    input wire pqtc_reg_req_t reg_req_i, // Register access strobes
    output logic [7:0] reg_rdata_o, // Read data, one cycle after rd
    output logic reg_rvalid_o, // Read data valid pulse
    input wire logic [VID_W-1:0] port_default_vlan_identifier_i [NPORT], // Ids
    input wire pqtc_cls_req_t cls_req_i [NPORT], // Ingress classify request
    output pqtc_cls_rsp_t cls_rsp_o [NPORT], // Ingress classify result
    input wire pqtc_egr_req_t egr_req_i [NPORT], // Egress edit request
    output pqtc_egr_rsp_t egr_rsp_o [NPORT], // Egress edit result
    input wire logic [NPORT-1:0] rx_pkt_i, // Packet received, per port pulse
    input wire logic [NPORT-1:0] tx_pkt_i, // Packet sent, per port pulse
    output logic [NPORT-1:0] sniff_dest_o, // Ports to copy monitored packet to
    output logic [NPORT-1:0] storm_protect_en_o, // Storm protection enable
    output logic [NPORT-1:0] multi_queue_en_o // Four-queue mode per port
);

    localparam logic [7:0] CTRL0_ADDR [3] = '{`PQTC_P1_CTRL0_ADDR,
        `PQTC_P2_CTRL0_ADDR, `PQTC_P3_CTRL0_ADDR};
    localparam logic [7:0] CTRL1_ADDR [3] = '{`PQTC_P1_CTRL1_ADDR,
        `PQTC_P2_CTRL1_ADDR, `PQTC_P3_CTRL1_ADDR};

    pqtc_ctrl0_t ctrl0_ff [NPORT];
    pqtc_ctrl0_t nxt_ctrl0 [NPORT];
    pqtc_ctrl1_t ctrl1_ff [NPORT];
    pqtc_ctrl1_t nxt_ctrl1 [NPORT];
    pqtc_cls_rsp_t cls_ff [NPORT];
    pqtc_cls_rsp_t nxt_cls [NPORT];
    pqtc_egr_rsp_t egr_ff [NPORT];
    pqtc_egr_rsp_t nxt_egr [NPORT];
    logic [NPORT-1:0] mon_hit;
    logic [NPORT-1:0] sniffer_sel;
    logic [NPORT-1:0] sniff_ff;
    logic [NPORT-1:0] nxt_sniff;
    logic [7:0] rdata_ff;
    logic [7:0] nxt_rdata;
    logic rvalid_ff;
    logic nxt_rvalid;

    genvar p;
    generate
        for (p = 0; p < NPORT; p++)
        begin : g_port
            // Register file, same layout per port
            always_comb
            begin
                nxt_ctrl0[p] = ctrl0_ff[p];
                nxt_ctrl1[p] = ctrl1_ff[p];
                if (reg_req_i.wr && reg_req_i.addr == CTRL0_ADDR[p])
                begin
                    nxt_ctrl0[p] = pqtc_ctrl0_t'(reg_req_i.wdata);
                end
                if (reg_req_i.wr && reg_req_i.addr == CTRL1_ADDR[p])
                begin
                    nxt_ctrl1[p] = pqtc_ctrl1_t'(reg_req_i.wdata
                        & `PQTC_CTRL1_MASK);
                end
            end

            // Ingress priority classification
            always_comb
            begin
                logic dscp_ok;
                logic dot1p_ok;
                logic [1:0] cls_prio;
                dscp_ok = ctrl0_ff[p].diffserv_cls_en
                    && cls_req_i[p].dscp_hit;
                dot1p_ok = ctrl0_ff[p].dot1p_cls_en
                    && cls_req_i[p].dot1p_hit;
                cls_prio = (dscp_ok ? cls_req_i[p].dscp_prio : 2'h0)
                    | (dot1p_ok ? cls_req_i[p].dot1p_prio : 2'h0);
                nxt_cls[p].valid = cls_req_i[p].valid;
                nxt_cls[p].storm_check = cls_req_i[p].valid
                    && ctrl0_ff[p].storm_protect_en;
                if (dscp_ok || dot1p_ok)
                begin
                    nxt_cls[p].prio = cls_prio;
                end
                else
                begin
                    nxt_cls[p].prio = ctrl0_ff[p].port_prio;
                end
            end

            // Egress tag edit and queue choice
            always_comb
            begin
                logic [1:0] src;
                src = egr_req_i[p].ingress_port;
                nxt_egr[p].valid = egr_req_i[p].valid;
                nxt_egr[p].add_tag = egr_req_i[p].valid
                    && ctrl0_ff[p].tag_insert_en
                    && !egr_req_i[p].rx_tagged;
                nxt_egr[p].strip_tag = egr_req_i[p].valid
                    && ctrl0_ff[p].tag_remove_en
                    && egr_req_i[p].rx_tagged;
                // Out-of-range source index yields a zero VID, not X
                if (32'(src) < NPORT)
                begin
                    nxt_egr[p].vid =
                        port_default_vlan_identifier_i[src];
                end
                else
                begin
                    nxt_egr[p].vid = `PQTC_NO_VID;
                end
                if (ctrl0_ff[p].multi_queue_en)
                begin
                    nxt_egr[p].queue = egr_req_i[p].prio;
                end
                else
                begin
                    nxt_egr[p].queue = `PQTC_SINGLE_QUEUE;
                end
            end

            // Monitoring marks
            assign mon_hit[p] = (rx_pkt_i[p] && ctrl1_ff[p].rx_sniff)
                || (tx_pkt_i[p] && ctrl1_ff[p].tx_sniff);
            assign sniffer_sel[p] = ctrl1_ff[p].sniffer_port;

            always_ff @(posedge ref_clk_i or negedge rst_n_i)
            begin
                if (!rst_n_i)
                begin
                    ctrl0_ff[p] <= pqtc_ctrl0_t'(`PQTC_CTRL0_RESET);
                    ctrl1_ff[p] <= pqtc_ctrl1_t'(`PQTC_CTRL1_RESET);
                    cls_ff[p] <= '0;
                    egr_ff[p] <= '0;
                end
                else
                begin
                    ctrl0_ff[p] <= nxt_ctrl0[p];
                    ctrl1_ff[p] <= nxt_ctrl1[p];
                    cls_ff[p] <= nxt_cls[p];
                    egr_ff[p] <= nxt_egr[p];
                end
            end

            assign cls_rsp_o[p] = cls_ff[p];
            assign egr_rsp_o[p] = egr_ff[p];
            assign storm_protect_en_o[p] =
                ctrl0_ff[p].storm_protect_en;
            assign multi_queue_en_o[p] = ctrl0_ff[p].multi_queue_en;
        end
    endgenerate

    // Copy of a monitored packet goes to every sniffer port
    always_comb
    begin
        nxt_sniff = (|mon_hit) ? sniffer_sel : '0;
    end

    // Read path; unmapped addresses read zero, reads change nothing
    always_comb
    begin
        nxt_rvalid = reg_req_i.rd;
        nxt_rdata = `PQTC_RDATA_RESET;
        for (int i = 0; i < NPORT; i++)
        begin
            if (reg_req_i.addr == CTRL0_ADDR[i])
            begin
                nxt_rdata = ctrl0_ff[i];
            end
            if (reg_req_i.addr == CTRL1_ADDR[i])
            begin
                nxt_rdata = ctrl1_ff[i];
            end
        end
        if (!reg_req_i.rd)
        begin
            nxt_rdata = rdata_ff;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            rdata_ff <= `PQTC_RDATA_RESET;
            rvalid_ff <= 1'b0;
            sniff_ff <= '0;
        end
        else
        begin
            rdata_ff <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
            sniff_ff <= nxt_sniff;
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;
    assign sniff_dest_o = sniff_ff;

endmodule

// ---- verification/pqtc_chk.sv ----
`timescale 1ns/1ns
module pqtc_chk
    import pqtc_pkg::*;
#(
    parameter int NPORT = 3,
    parameter int VID_W = 12
)(
    input wire logic ref_clk_i, // Clock
    input wire logic rst_n_i, // Reset
    input wire pqtc_reg_req_t reg_req_i, // Bus
    input wire logic [7:0] reg_rdata_o, // Data
    input wire logic reg_rvalid_o, // Valid
    input wire logic [VID_W-1:0] port_default_vlan_identifier_i [NPORT], // Vid
    input wire pqtc_cls_req_t cls_req_i [NPORT], // Cls req
    input wire pqtc_cls_rsp_t cls_rsp_o [NPORT], // Cls rsp
    input wire pqtc_egr_req_t egr_req_i [NPORT], // Egr req
    input wire pqtc_egr_rsp_t egr_rsp_o [NPORT], // Egr rsp
    input wire logic [NPORT-1:0] rx_pkt_i, // Rx
    input wire logic [NPORT-1:0] tx_pkt_i, // Tx
    input wire logic [NPORT-1:0] sniff_dest_o, // Sniff
    input wire logic [NPORT-1:0] storm_protect_en_o, // Storm
    input wire logic [NPORT-1:0] multi_queue_en_o // Queues
);
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    sequence s_rd_req;
        reg_req_i.rd;
    endsequence
    sequence s_rd_ans;
        reg_rvalid_o;
    endsequence
    a_read_answer: assert property (s_rd_req |=> s_rd_ans)
        else $error("read not answered");
    a_read_quiet: assert property (!reg_req_i.rd |=> !reg_rvalid_o)
        else $error("spurious read valid");
    a_storm_follow: assert property (cls_req_i[0].valid |=>
        cls_rsp_o[0].storm_check == $past(storm_protect_en_o[0]))
        else $error("storm check wrong");
    a_single_queue: assert property (egr_req_i[1].valid &&
        !multi_queue_en_o[1] |=> egr_rsp_o[1].queue == 2'h0)
        else $error("single queue wrong");
    a_four_queue: assert property (egr_req_i[1].valid &&
        multi_queue_en_o[1] |=> egr_rsp_o[1].queue == $past(egr_req_i[1].prio))
        else $error("queue not prio");
    a_tag_once: assert property (egr_req_i[1].valid &&
        egr_req_i[1].rx_tagged |=> !egr_rsp_o[1].add_tag)
        else $error("tag added twice");
    a_untag_kept: assert property (egr_req_i[1].valid &&
        !egr_req_i[1].rx_tagged |=> !egr_rsp_o[1].strip_tag)
        else $error("untagged stripped");
    a_ingress_vid: assert property (egr_req_i[1].valid &&
        egr_req_i[1].ingress_port == 2'h2 |=>
        egr_rsp_o[1].vid == $past(port_default_vlan_identifier_i[2]))
        else $error("vid not ingress");
    a_sniff_idle: assert property (rx_pkt_i == '0 &&
        tx_pkt_i == '0 |=> sniff_dest_o == '0)
        else $error("sniff without event");
endmodule

bind pqtc_top pqtc_chk #(.NPORT(NPORT), .VID_W(VID_W)) u_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_req_i(reg_req_i),
    .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
    .port_default_vlan_identifier_i(port_default_vlan_identifier_i),
    .cls_req_i(cls_req_i), .cls_rsp_o(cls_rsp_o), .egr_req_i(egr_req_i),
    .egr_rsp_o(egr_rsp_o), .rx_pkt_i(rx_pkt_i), .tx_pkt_i(tx_pkt_i),
    .sniff_dest_o(sniff_dest_o), .storm_protect_en_o(storm_protect_en_o),
    .multi_queue_en_o(multi_queue_en_o));

// ---- verification/tb.sv ----
`timescale 1ns/1ns
module tb;
    import pqtc_pkg::*;
    logic ref_clk_i = 1'b0;
    logic rst_n_i = 1'b0;
    pqtc_reg_req_t reg_req_i = '0;
    logic [7:0] reg_rdata_o;
    logic reg_rvalid_o;
    logic [11:0] vid_i [3] = '{12'h111, 12'h222, 12'h333};
    pqtc_cls_req_t cls_req_i [3] = '{default: '0};
    pqtc_cls_rsp_t cls_rsp_o [3];
    pqtc_egr_req_t egr_req_i [3] = '{default: '0};
    pqtc_egr_rsp_t egr_rsp_o [3];
    logic [2:0] rx_pkt_i = '0;
    logic [2:0] tx_pkt_i = '0;
    logic [2:0] sniff_dest_o, storm_protect_en_o, multi_queue_en_o;
    int n_mismatch = 0;
    int compares = 0;
    logic [7:0] c_ctl [5] = '{8'h98, 8'h68, 8'h50, 8'h30, 8'h68};
    logic [6:0] c_req [5] = '{7'h6e, 7'h6e, 7'h6e, 7'h6e, 7'h5b};
    logic [16:0] c_exp [5] = '{17'hf, 17'hb, 17'h9, 17'ha, 17'h9};
    logic [7:0] e_ctl [6] = '{8'h04, 8'h04, 8'h02, 8'h02, 8'h01, 8'h00};
    logic [5:0] e_req [6] = '{6'h28, 6'h30, 6'h30, 6'h24, 6'h22, 6'h23};
    logic [16:0] e_exp [6] = '{17'h18ccc, 17'h10444, 17'h14444, 17'h10888,
        17'h10446, 17'h10444};

    pqtc_top dut (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
        .reg_req_i(reg_req_i), .reg_rdata_o(reg_rdata_o),
        .reg_rvalid_o(reg_rvalid_o), .port_default_vlan_identifier_i(vid_i),
        .cls_req_i(cls_req_i), .cls_rsp_o(cls_rsp_o), .egr_req_i(egr_req_i),
        .egr_rsp_o(egr_rsp_o), .rx_pkt_i(rx_pkt_i), .tx_pkt_i(tx_pkt_i),
        .sniff_dest_o(sniff_dest_o), .storm_protect_en_o(storm_protect_en_o),
        .multi_queue_en_o(multi_queue_en_o));

    task automatic chk(input logic [16:0] seen, input logic [16:0] exp);
        compares++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (n_mismatch == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        reg_req_i <= '{1'b1, 1'b0, a, d};
        @(posedge ref_clk_i);
        reg_req_i <= '0;
    endtask

    // Answer stands one cycle, so look just after the taking edge
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk_i);
        reg_req_i <= '{1'b0, 1'b1, a, 8'h00};
        @(posedge ref_clk_i);
        reg_req_i <= '0;
        #1 chk(17'({reg_rvalid_o, reg_rdata_o}), 17'({1'b1, e}));
    endtask

    task automatic pulse(input logic [2:0] rx, input logic [2:0] tx,
        input logic [2:0] e);
        @(posedge ref_clk_i);
        rx_pkt_i <= rx;
        tx_pkt_i <= tx;
        @(posedge ref_clk_i);
        rx_pkt_i <= '0;
        tx_pkt_i <= '0;
        #1 chk(17'(sniff_dest_o), 17'(e));
    endtask

    initial
    begin
        forever #20 ref_clk_i = ~ref_clk_i;
    end

    initial
    begin
        #100000;
        n_mismatch++;
        end_sim();
    end

    initial
    begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        for (int p = 1; p < 4; p++)
        begin
            rd(8'(p << 4), 8'h00);
            rd(8'((p << 4) + 1), 8'h00);
        end
        for (int p = 0; p < 3; p++)
            for (int i = 0; i < 5; i++)
            begin
                wr(8'((p + 1) << 4), c_ctl[i]);
                rd(8'((p + 1) << 4), c_ctl[i]);
                @(posedge ref_clk_i);
                cls_req_i[p] <= c_req[i];
                @(posedge ref_clk_i);
                cls_req_i[p] <= '0;
                #1 chk(17'(cls_rsp_o[p]), c_exp[i]);
            end
        for (int i = 0; i < 6; i++)
        begin
            wr(8'h20, e_ctl[i]);
            @(posedge ref_clk_i);
            egr_req_i[1] <= e_req[i];
            @(posedge ref_clk_i);
            egr_req_i[1] <= '0;
            #1 chk(17'(egr_rsp_o[1]), e_exp[i]);
        end
        // Port 3 with insert, remove and four queues; port 1 plain
        wr(8'h30, 8'h07);
        @(posedge ref_clk_i);
        egr_req_i[2] <= 6'h3f;
        egr_req_i[0] <= 6'h29;
        @(posedge ref_clk_i);
        egr_req_i[2] <= '0;
        egr_req_i[0] <= '0;
        #1 chk(17'(egr_rsp_o[2]), 17'h14003);
        chk(17'(egr_rsp_o[0]), 17'h10ccc);
        wr(8'h31, 8'h80);
        wr(8'h11, 8'h40);
        pulse(3'b001, 3'b000, 3'b100);
        pulse(3'b000, 3'b001, 3'b000);
        wr(8'h11, 8'h20);
        pulse(3'b000, 3'b001, 3'b100);
        wr(8'h10, 8'h85);
        #1 chk(17'({storm_protect_en_o, multi_queue_en_o}), 17'h0d);
        rd(8'h12, 8'h00);
        wr(8'h40, 8'hff);
        rd(8'h10, 8'h85);
        wr(8'h21, 8'hff);
        rd(8'h21, 8'he0);
        end_sim();
    end
endmodule
